/* File: sdbg_pkg.sv */
// constants, types and states for the single pin debug unit
// How it works
// - one shared open-drain debug pin
// - never transmit while receiving, and vice versa
// - start low, eight bits lsb first, stop high
// - debug mode halts instruction fetch
// - clocks and peripherals keep running
// - debug mode entry leaves halt state
// - refresh enabled watchdog throughout debug mode
// - breakpoint instruction enters debug mode
// - pin low at reset end enters debug
// - small package needs 32-bit key under reset
// - writing mode bit zero leaves debug
// - system resets leave debug mode
// - pin low in stop starts reset
// - reply may start mid stop bit, once it is sampled
// - transmitter, receiver, autobaud, controller parts
// - slowest baud is clock over 512
// - nine low bits is break, reset autobaud
// - errors abort, send four-character break, rebaud
package sdbg_pkg;
  localparam int unsigned CLK_HZ            = 100_000_000;
  localparam int unsigned SDBG_HOST_HOLD_CYC = 5000;
  localparam logic [9:0]  SDBG_MAX_BITP     = 10'h200;
  localparam logic [9:0]  SDBG_MIN_BITP     = 10'h004;
  localparam logic [12:0] SDBG_BAUD_MAX_CNT = 13'h1007;
  localparam logic [3:0]  SDBG_BREAK_BITS   = 4'h9;
  localparam logic [3:0]  SDBG_STOP_IDX     = 4'h9;
  localparam logic [5:0]  SDBG_BRK_TX_BITS  = 6'h28;
  localparam logic [31:0] SDBG_UNLOCK_KEY   = 32'hebaa70cd ^ 32'h00f00000;
  localparam logic [1:0]  SDBG_KEY_LAST     = 2'h3;
  localparam int unsigned SDBG_FIFO_DEPTH   = 32;
  localparam int unsigned SDBG_DATA_W       = 8;

  typedef enum logic [6:0] {
    ST_BAUD_WAIT  = 7'h01,
    ST_BAUD_MEAS  = 7'h02,
    ST_IDLE       = 7'h04,
    ST_RX         = 7'h08,
    ST_TX         = 7'h10,
    ST_BREAK_TX   = 7'h20,
    ST_BREAK_WAIT = 7'h40
  } sdbg_state_t;

  typedef struct packed {
    logic brk_exec;
    logic brk_enable;
    logic mode_set;
    logic mode_clr;
    logic stop_mode;
    logic halt_mode;
    logic wdt_enabled;
    logic sys_reset;
    logic small_pkg;
    logic rst_pin_low;
  } sdbg_sys_t;

  typedef struct packed {
    logic fetch_halt;
    logic halt_exit;
    logic wdt_refresh;
    logic sys_reset_req;
  } sdbg_cpu_t;
endpackage

/* File: sdbg_top.sv */
// single pin debug unit: autobaud, receiver, transmitter, mode control and tx fifo
`timescale 1ns/1ps
`default_nettype none

module sdbg_fifo #(
  parameter int unsigned W = 8,
  parameter int unsigned D = 32
) (
  input  wire logic         core_clk, // system clock
  input  wire logic         rst,      // sync reset, active high
  input  wire logic         clr,      // flush contents
  input  wire logic [W-1:0] in_data,  // write data
  input  wire logic         in_valid, // write request
  output logic              in_ready, // not full
  output logic      [W-1:0] out_data, // head word
  output logic              out_valid,// not empty
  input  wire logic         out_ready // head consumed
);
  localparam int unsigned AW = $clog2(D);
  logic [W-1:0]  mem_r [D];
  logic [AW-1:0] wp_r, rp_r, wp_nxt, rp_nxt;
  logic [AW:0]   cnt_r, cnt_nxt;
  logic          wr, rd;

  always_comb begin
    in_ready  = (cnt_r != D[AW:0]);
    out_valid = (cnt_r != '0);
    out_data  = mem_r[rp_r];
    wr        = in_valid && in_ready;
    rd        = out_valid && out_ready;
    wp_nxt    = wr ? wp_r + 1'b1 : wp_r;
    rp_nxt    = rd ? rp_r + 1'b1 : rp_r;
    cnt_nxt   = cnt_r + {{AW{1'b0}}, wr} - {{AW{1'b0}}, rd};
    if (clr) begin
      wp_nxt  = '0;
      rp_nxt  = '0;
      cnt_nxt = '0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (wr) begin
      mem_r[wp_r] <= in_data;
    end
    if (rst) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end
endmodule

module sdbg_top
  import sdbg_pkg::*;
(
  input  wire logic       core_clk,            // system clock, 100 MHz
  input  wire logic       rst,                 // sync reset of the unit, active high
  input  wire logic       debug_serial_pin_i,  // debug pin level
  output logic            debug_serial_pin_o,  // debug pin drive value, always low
  output logic            debug_serial_pin_oe, // high while pulling the pin low
  input  wire sdbg_sys_t  sys,                 // cpu and system status
  output sdbg_cpu_t       cpu,                 // controls toward the cpu
  input  wire logic [7:0] tx_data,             // reply byte from the controller
  input  wire logic       tx_valid,            // reply byte offered
  output logic            tx_ready,            // reply fifo has room
  output logic      [7:0] rx_data,             // received byte
  output logic            rx_valid,            // one-cycle pulse per byte
  output logic            cmd_abort,           // one-cycle pulse on a link error
  output logic            baud_locked          // baud rate measured
);
  sdbg_state_t state_r, state_nxt;
  logic        pin_s1_r, pin_s2_r;
  logic [12:0] cnt_r, cnt_nxt;
  logic [9:0]  bitp_r, bitp_nxt;
  logic [5:0]  idx_r, idx_nxt;
  logic [3:0]  lowrun_r, lowrun_nxt;
  logic [9:0]  sh_r, sh_nxt;
  logic        oe_r, oe_nxt;
  logic [7:0]  rxd_r, rxd_nxt;
  logic        rxv_r, rxv_nxt, err_r, err_nxt, flush;
  logic        mode_r, mode_nxt, strap_r, strap_nxt, in_rst_r;
  logic        unlk_r, unlk_nxt, link_en;
  logic [1:0]  key_r, key_nxt;
  logic [7:0]  f_data;
  logic        f_valid, f_pop;
  logic [12:0] mid;

  // two flops; only the second stage is ever looked at
  always_ff @(posedge core_clk) begin
    pin_s1_r <= debug_serial_pin_i;
    pin_s2_r <= pin_s1_r;
  end

  sdbg_fifo #(.W(SDBG_DATA_W), .D(SDBG_FIFO_DEPTH)) u_txq (
    .core_clk  (core_clk),
    .rst       (rst),
    .clr       (flush),
    .in_data   (tx_data),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .out_data  (f_data),
    .out_valid (f_valid),
    .out_ready (f_pop)
  );

  // locked small package: pin only listens for the key while reset pin is low
  assign link_en = !sys.small_pkg || unlk_r || sys.rst_pin_low;
  assign mid     = {4'h0, bitp_r[9:1]};

  // serial engine: autobaud, receive, transmit, break
  always_comb begin
    state_nxt  = state_r;
    cnt_nxt    = cnt_r;
    bitp_nxt   = bitp_r;
    idx_nxt    = idx_r;
    lowrun_nxt = lowrun_r;
    sh_nxt     = sh_r;
    oe_nxt     = 1'b0;
    rxd_nxt    = rxd_r;
    rxv_nxt    = 1'b0;
    err_nxt    = 1'b0;
    f_pop      = 1'b0;
    case (state_r)
      ST_BAUD_WAIT: begin
        cnt_nxt = '0;
        if (!pin_s2_r) begin
          state_nxt = ST_BAUD_MEAS;
        end
      end
      ST_BAUD_MEAS: begin
        cnt_nxt = cnt_r + 13'h1; // low cycles so far, the one seen in baud-wait included
        if (cnt_nxt > SDBG_BAUD_MAX_CNT) begin
          state_nxt = ST_BREAK_WAIT; // too slow: treated as a break, long strap holds land here
        end else if (pin_s2_r) begin
          bitp_nxt  = cnt_nxt[12:3]; // eight low bits of 80h
          state_nxt = (cnt_nxt[12:3] < SDBG_MIN_BITP) ? ST_BAUD_WAIT : ST_IDLE;
        end
      end
      ST_IDLE: begin
        lowrun_nxt = '0;
        idx_nxt    = '0;
        if (!pin_s2_r) begin
          state_nxt = ST_RX; // receive has priority, never start tx over it
          cnt_nxt   = mid;   // first sample lands mid start bit
        end else if (f_valid && (unlk_r || !sys.small_pkg)) begin
          f_pop     = 1'b1;  // reply may start once the stop bit is sampled, mid bit
          sh_nxt    = {1'b1, f_data, 1'b0};
          oe_nxt    = 1'b1;
          cnt_nxt   = {3'h0, bitp_r} - 13'h1;
          state_nxt = ST_TX;
        end
      end
      ST_RX: begin
        cnt_nxt = cnt_r - 13'h1;
        if (cnt_r == '0) begin
          cnt_nxt    = {3'h0, bitp_r} - 13'h1;
          idx_nxt    = idx_r + 6'h1;
          lowrun_nxt = pin_s2_r ? 4'h0 : lowrun_r + 4'h1;
          if (idx_r == '0 && pin_s2_r) begin
            state_nxt = ST_IDLE; // glitch, not a start bit
          end else if (!pin_s2_r && lowrun_r == SDBG_BREAK_BITS - 4'h1) begin
            err_nxt   = 1'b1; // break
            idx_nxt   = '0;
            state_nxt = ST_BREAK_TX;
          end else if (idx_r[3:0] == SDBG_STOP_IDX) begin
            if (pin_s2_r) begin
              rxv_nxt   = 1'b1;
              state_nxt = ST_IDLE;
            end else begin
              err_nxt   = 1'b1; // framing error
              idx_nxt   = '0;
              state_nxt = ST_BREAK_TX;
            end
          end else if (idx_r != '0) begin
            rxd_nxt = {pin_s2_r, rxd_r[7:1]}; // lsb first
          end
        end
      end
      ST_TX: begin
        cnt_nxt = cnt_r - 13'h1;
        oe_nxt  = !sh_r[0]; // drive only low bits, release high ones
        if (cnt_r == mid && sh_r[0] && !pin_s2_r) begin
          err_nxt   = 1'b1; // collision: host pulled a released bit low
          idx_nxt   = '0;
          oe_nxt    = 1'b1;
          state_nxt = ST_BREAK_TX;
        end else if (cnt_r == '0) begin
          cnt_nxt = {3'h0, bitp_r} - 13'h1;
          idx_nxt = idx_r + 6'h1;
          sh_nxt  = {1'b1, sh_r[9:1]};
          oe_nxt  = !sh_r[1];
          if (idx_r[3:0] == SDBG_STOP_IDX) begin
            oe_nxt    = 1'b0;
            state_nxt = ST_IDLE;
          end
        end
      end
      ST_BREAK_TX: begin
        oe_nxt  = 1'b1; // four characters of solid low
        cnt_nxt = cnt_r - 13'h1;
        if (cnt_r == '0) begin
          cnt_nxt = {3'h0, bitp_r} - 13'h1;
          idx_nxt = idx_r + 6'h1;
          if (idx_r == SDBG_BRK_TX_BITS - 6'h1) begin
            oe_nxt    = 1'b0;
            state_nxt = ST_BREAK_WAIT;
          end
        end
      end
      ST_BREAK_WAIT: begin
        if (pin_s2_r && !oe_r) begin
          state_nxt = ST_BAUD_WAIT; // rebaud with 80h
        end
      end
      default: state_nxt = ST_BAUD_WAIT;
    endcase
    if (!link_en) begin
      state_nxt = ST_BAUD_WAIT;
      oe_nxt    = 1'b0;
    end
  end

  assign flush = err_r || !link_en;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_r  <= ST_BAUD_WAIT;
      cnt_r    <= '0;
      bitp_r   <= SDBG_MAX_BITP;
      idx_r    <= '0;
      lowrun_r <= '0;
      sh_r     <= '1;
      oe_r     <= 1'b0;
      rxd_r    <= '0;
      rxv_r    <= 1'b0;
      err_r    <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      cnt_r    <= cnt_nxt;
      bitp_r   <= bitp_nxt;
      idx_r    <= idx_nxt;
      lowrun_r <= lowrun_nxt;
      sh_r     <= sh_nxt;
      oe_r     <= oe_nxt;
      rxd_r    <= rxd_nxt;
      rxv_r    <= rxv_nxt;
      err_r    <= err_nxt;
    end
  end

  // debug mode, strap and unlock key
  always_comb begin
    mode_nxt  = mode_r;
    strap_nxt = strap_r;
    unlk_nxt  = unlk_r;
    key_nxt   = key_r;
    if (sys.mode_clr) begin
      mode_nxt = 1'b0;
    end
    if (sys.mode_set || (sys.brk_exec && sys.brk_enable)) begin
      mode_nxt = 1'b1; // set wins over a same-cycle clear
    end
    if (sys.sys_reset) begin
      mode_nxt  = 1'b0;
      strap_nxt = !pin_s2_r && link_en; // last reset cycle's value survives
    end else if (in_rst_r) begin
      mode_nxt  = strap_r;
    end
    if (rxv_r && sys.small_pkg && !unlk_r && sys.rst_pin_low) begin
      if (rxd_r == SDBG_UNLOCK_KEY[31 - 8*key_r -: 8]) begin
        key_nxt  = key_r + 2'h1;
        unlk_nxt = (key_r == SDBG_KEY_LAST);
      end else begin
        key_nxt = '0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      mode_r   <= 1'b0;
      strap_r  <= 1'b0;
      in_rst_r <= 1'b0;
      unlk_r   <= 1'b0;
      key_r    <= '0;
    end else begin
      mode_r   <= mode_nxt;
      strap_r  <= strap_nxt;
      in_rst_r <= sys.sys_reset;
      unlk_r   <= unlk_nxt;
      key_r    <= key_nxt;
    end
  end

  // clock is never gated here; peripherals run on in debug mode
  always_comb begin
    cpu.fetch_halt    = mode_r;
    cpu.halt_exit     = mode_r && sys.halt_mode;
    cpu.wdt_refresh   = mode_r && sys.wdt_enabled;
    cpu.sys_reset_req = sys.stop_mode && !pin_s2_r && link_en;
  end

  assign debug_serial_pin_o  = 1'b0;
  assign debug_serial_pin_oe = oe_r;
  assign rx_data             = rxd_r;
  assign rx_valid            = rxv_r;
  assign cmd_abort           = err_r;
  assign baud_locked         = !(state_r inside {ST_BAUD_WAIT, ST_BAUD_MEAS});

  chk_brk_enter: assert property (@(posedge core_clk) disable iff (rst)
    sys.brk_exec && sys.brk_enable && !sys.sys_reset |=> cpu.fetch_halt)
    else $error("breakpoint did not enter debug mode");
  chk_mode_exit: assert property (@(posedge core_clk) disable iff (rst)
    sys.mode_clr && !sys.mode_set && !sys.brk_exec && !in_rst_r |=> !cpu.fetch_halt)
    else $error("mode clear ignored");
  chk_reset_exit: assert property (@(posedge core_clk) disable iff (rst)
    sys.sys_reset ##1 sys.sys_reset |-> !cpu.fetch_halt)
    else $error("debug mode held through reset");
  chk_strap_entry: assert property (@(posedge core_clk) disable iff (rst)
    sys.sys_reset && !pin_s2_r && link_en ##1 !sys.sys_reset |=> cpu.fetch_halt)
    else $error("strap low did not enter debug mode");
  chk_halt_wdt: assert property (@(posedge core_clk) disable iff (rst)
    cpu.fetch_halt |-> (cpu.wdt_refresh == sys.wdt_enabled) && (cpu.halt_exit == sys.halt_mode))
    else $error("watchdog or halt handling wrong in debug");
  chk_stop_wake: assert property (@(posedge core_clk) disable iff (rst)
    sys.stop_mode && !pin_s2_r && !sys.small_pkg |-> cpu.sys_reset_req)
    else $error("pin low in stop did not request reset");
  chk_half_duplex: assert property (@(posedge core_clk) disable iff (rst)
    state_r == ST_RX |-> !debug_serial_pin_oe)
    else $error("driving pin while receiving");
  chk_start_low: assert property (@(posedge core_clk) disable iff (rst)
    state_r == ST_IDLE ##1 state_r == ST_TX |-> debug_serial_pin_oe)
    else $error("start bit not driven low");
  chk_baud_range: assert property (@(posedge core_clk) disable iff (rst)
    baud_locked |-> bitp_r >= SDBG_MIN_BITP && bitp_r <= SDBG_MAX_BITP)
    else $error("bit period out of range");
  chk_error_break: assert property (@(posedge core_clk) disable iff (rst)
    cmd_abort && link_en |-> state_r == ST_BREAK_TX ##1 debug_serial_pin_oe)
    else $error("error did not start a break");

  cov_baud: cover property (@(posedge core_clk) disable iff (rst)
    state_r == ST_BAUD_MEAS ##1 state_r == ST_IDLE);
  cov_rx_byte: cover property (@(posedge core_clk) disable iff (rst) rx_valid);
  cov_tx_done: cover property (@(posedge core_clk) disable iff (rst)
    state_r == ST_TX ##1 state_r == ST_IDLE);
  cov_break: cover property (@(posedge core_clk) disable iff (rst) cmd_abort);
endmodule

`default_nettype wire

/* File: sdbg_host.sv */
// host side model of the debug link: open-drain sender and character receiver
`timescale 1ns/1ps
`default_nettype none
module sdbg_host (
  input  wire logic core_clk, // system clock
  input  wire logic pin,      // resolved pin level
  output logic      pull_low  // host pulls the pin low
);
  int bitp = 16;
  initial pull_low = 1'b0;
  // a one only releases the pin, so a stop bit is never driven high
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0}; // start low, lsb first, stop high
    for (int i = 0; i < 10; i++) begin
      pull_low <= ~f[i];
      repeat (bitp) @(negedge core_clk);
    end
  endtask
  task automatic hold_low(input int n);
    pull_low <= 1'b1;
    repeat (n) @(negedge core_clk);
    pull_low <= 1'b0;
  endtask
  // waits for a start bit, then samples each bit near its middle
  task automatic recv(output logic [7:0] b, output bit ok);
    int t;
    t = 0;
    ok = 0;
    b = 8'h00;
    while (pin !== 1'b0 && t < 4000) begin
      @(negedge core_clk);
      t++;
    end
    if (t < 4000) begin
      repeat (bitp / 2) @(negedge core_clk);
      for (int i = 0; i < 8; i++) begin
        repeat (bitp) @(negedge core_clk);
        b[i] = pin;
      end
      repeat (bitp) @(negedge core_clk);
      ok = (pin === 1'b1);
    end
  endtask
endmodule
`default_nettype wire

/* File: sdbg_top_tb.sv */
// self-checking testbench of the single pin debug unit
`timescale 1ns/1ps
`default_nettype none
module sdbg_top_tb
  import sdbg_pkg::*;
;
  logic       core_clk = 1'b0;
  logic       rst      = 1'b1;
  logic       pin;
  logic       host_low;
  logic       pin_o;
  logic       pin_oe;
  sdbg_sys_t  sys      = '0;
  sdbg_cpu_t  cpu;
  logic [7:0] tx_data  = 8'h00;
  logic       tx_valid = 1'b0;
  logic       tx_ready;
  logic [7:0] rx_data;
  logic       rx_valid;
  logic       cmd_abort;
  logic       baud_locked;
  logic [7:0] got      = 8'h00;
  int         n_rx     = 0;
  int         n_abort  = 0;
  int         oe_busy  = 0;
  bit         host_tx  = 0;
  int         n_errors = 0;
  int         checked  = 0;

  always #5 core_clk = ~core_clk;
  // the pin is high unless some party pulls it low
  assign pin = ~(host_low | (pin_oe & ~pin_o));

  sdbg_host host (.core_clk(core_clk), .pin(pin), .pull_low(host_low));

  sdbg_top dut (
    .core_clk(core_clk), .rst(rst), .debug_serial_pin_i(pin), .debug_serial_pin_o(pin_o),
    .debug_serial_pin_oe(pin_oe), .sys(sys), .cpu(cpu), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid), .cmd_abort(cmd_abort),
    .baud_locked(baud_locked)
  );

  always @(posedge core_clk) begin
    if (rx_valid === 1'b1) begin
      got <= rx_data;
      n_rx <= n_rx + 1;
    end
    if (cmd_abort === 1'b1) n_abort <= n_abort + 1;
    if (host_tx && pin_oe === 1'b1) oe_busy <= oe_busy + 1;
  end

  task automatic check(input bit c, input string m);
    checked++;
    if (!c) begin
      n_errors++;
      $display("BAD %0t %s", $time, m);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic pulse_sys(input sdbg_sys_t v);
    sys = sys | v;
    @(negedge core_clk);
    sys = sys & ~v;
    @(negedge core_clk);
  endtask

  task automatic t_reset();
    check(pin_oe === 1'b0 && baud_locked === 1'b0 && tx_ready === 1'b1, "reset outputs");
    check(cpu.fetch_halt === 1'b0, "fetch halted after reset");
    $display("test reset done");
  endtask

  task automatic t_baud();
    host.send(8'h80);
    check(baud_locked === 1'b1, "no baud lock");
    $display("test autobaud done");
  endtask

  // reply queued while the host is mid-frame must wait, then may start mid stop bit
  task automatic t_rxtx();
    logic [7:0] b;
    bit         ok;
    int         n0;
    n0 = n_rx;
    fork
      host.send(8'h4e);
      begin
        // window ends mid stop bit: from there on the device may already reply
        host_tx = 1;
        repeat (host.bitp * 19 / 2) @(negedge core_clk);
        host_tx = 0;
      end
      begin
        repeat (30) @(negedge core_clk);
        check(tx_ready === 1'b1, "fifo not ready");
        tx_data = 8'hc3;
        tx_valid = 1'b1;
        @(negedge core_clk);
        tx_valid = 1'b0;
      end
      begin
        // the reply starts during the host's stop bit, so listen from the byte's arrival on
        wait (rx_valid === 1'b1);
        host.recv(b, ok);
      end
    join
    check(oe_busy == 0, "drove pin while receiving");
    check(n_rx == n0 + 1 && got === 8'h4e, "received byte wrong");
    check(ok && b === 8'hc3, "reply byte wrong");
    $display("test receive and reply done");
  endtask

  task automatic t_break();
    int t;
    int n0;
    n0 = n_abort;
    t = 0;
    host.hold_low(10 * 16);
    while (pin === 1'b0 && t < 2000) begin
      @(negedge core_clk);
      t++;
    end
    // the released pin needs the synchroniser and one state step before baud-wait
    repeat (4) @(negedge core_clk);
    check(n_abort == n0 + 1, "no abort on break");
    check(baud_locked === 1'b0, "autobaud not reset");
    // device break is 40 bit times from detection, most of it after the host let go
    check(t >= 500 && t <= 700, "break length wrong");
    host.send(8'h80);
    check(baud_locked === 1'b1, "no relock");
    $display("test break done");
  endtask

  task automatic t_mode();
    sdbg_sys_t v;
    v = '0;
    v.brk_exec = 1'b1;
    pulse_sys(v);
    check(cpu.fetch_halt === 1'b0, "disabled breakpoint entered");
    sys.brk_enable = 1'b1;
    pulse_sys(v);
    check(cpu.fetch_halt === 1'b1, "breakpoint not entered");
    sys.wdt_enabled = 1'b1;
    sys.halt_mode = 1'b1;
    @(negedge core_clk);
    check(cpu.wdt_refresh === 1'b1 && cpu.halt_exit === 1'b1, "refresh or halt exit");
    v = '0;
    v.mode_clr = 1'b1;
    pulse_sys(v);
    check(cpu.fetch_halt === 1'b0 && cpu.wdt_refresh === 1'b0, "mode clear");
    v = '0;
    v.mode_set = 1'b1;
    pulse_sys(v);
    check(cpu.fetch_halt === 1'b1, "mode set");
    v = '0;
    v.sys_reset = 1'b1;
    pulse_sys(v);
    repeat (2) @(negedge core_clk);
    check(cpu.fetch_halt === 1'b0, "reset kept debug");
    sys = '0;
    $display("test mode control done");
  endtask

  task automatic t_strap();
    int t;
    t = 0;
    fork
      host.hold_low(5200);
      begin
        repeat (5) @(negedge core_clk);
        sys.stop_mode = 1'b1;
        repeat (3) @(negedge core_clk);
        check(cpu.sys_reset_req === 1'b1, "no reset from stop");
        sys.stop_mode = 1'b0;
        sys.sys_reset = 1'b1;
        repeat (3) @(negedge core_clk);
        sys.sys_reset = 1'b0;
        repeat (4) @(negedge core_clk);
        check(cpu.fetch_halt === 1'b1, "strap entry missing");
      end
    join
    while (pin === 1'b0 && t < 2000) begin
      @(negedge core_clk);
      t++;
    end
    sys.sys_reset = 1'b1;
    repeat (3) @(negedge core_clk);
    sys.sys_reset = 1'b0;
    repeat (4) @(negedge core_clk);
    check(cpu.fetch_halt === 1'b0, "reset with pin high entered");
    $display("test strap done");
  endtask

  // small package: the pin stays dead until the key arrives under a held reset pin
  task automatic t_unlock();
    sys.small_pkg = 1'b1;
    host.send(8'h80);
    check(baud_locked === 1'b0, "locked pin answered autobaud");
    sys.rst_pin_low = 1'b1;
    host.send(8'h80);
    host.send(8'heb);
    host.send(8'h5a);
    host.send(8'h70);
    host.send(8'hcd);
    sys.rst_pin_low = 1'b0;
    repeat (2) @(negedge core_clk);
    check(baud_locked === 1'b1, "key did not unlock the pin");
    $display("test unlock done");
  endtask

  initial begin
    repeat (6) @(negedge core_clk);
    rst = 1'b0;
    @(negedge core_clk);
    t_reset();
    t_baud();
    t_rxtx();
    t_break();
    t_mode();
    t_strap();
    t_unlock();
    summarize();
  end

  // all tests take about 7.5k cycles; give them four times that
  initial begin
    #300_000;
    n_errors++;
    $display("BAD %0t watchdog expired", $time);
    summarize();
  end
endmodule
`default_nettype wire
